// file: verilog/light_regs_consts.vh
// register map, field positions and reset values of the sensor register slice
// assumes inclusion by the register slice and its bench only
`ifndef LIGHT_REGS_CONSTS_VH
`define LIGHT_REGS_CONSTS_VH

// register offsets on the serial register port
`define OFF_SENSOR_CONFIG_ONE 8'h90
`define OFF_REVISION_CODE 8'h91
`define OFF_DEVICE_TYPE_CODE 8'h92
`define OFF_EVENT_FLAGS 8'h93
`define OFF_CLEAR_RESULT_LOW 8'h94
`define OFF_CLEAR_RESULT_HIGH 8'h95
`define OFF_RED_RESULT_LOW 8'h96
`define OFF_RED_RESULT_HIGH 8'h97

// sensor_config_one fields
`define CFG_IR_SEL_BIT 6
`define CFG_CURRENT_NORM_BIT 5
`define CFG_GAIN_MSB 4
`define CFG_GAIN_LSB 0
`define CFG_RESET 8'h09

// event_flags bit positions
`define FLAG_LIGHT_SAT 7
`define FLAG_PROX_SAT 6
`define FLAG_PROX_THR 5
`define FLAG_LIGHT_THR 4
`define FLAG_CALIB_DONE 3
`define FLAG_ZERO_DEC 2
`define FLAG_SAT_EMIT_ON 1
`define FLAG_SAT_EMIT_OFF 0
`define FLAGS_RESET 8'h00
`define RESULT_RESET 8'h00

// light gain codes and their gain as a power of two
`define GAIN_CODE_1X 5'h01
`define GAIN_CODE_4X 5'h03
`define GAIN_CODE_16X 5'h05
`define GAIN_CODE_64X 5'h07
`define GAIN_CODE_128X 5'h08
`define GAIN_CODE_256X 5'h09
`define GAIN_CODE_512X 5'h0A

// serial port: default target address, arbitrary value
`define BUS_ADDR_DEFAULT 7'h2A
// identification values, arbitrary
`define REV_CODE_DEFAULT 3'h5
`define TYPE_CODE_DEFAULT 6'h2A

`endif

// file: verilog/pin_sync.v
// two flip-flop synchroniser for pin levels entering the ref_clk domain
// assumes the inputs are asynchronous levels; output is safe to decode
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter WIDTH = 2,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] pin_sync_out
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // first stage feeds only the second stage
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      meta_q <= INIT;
      sync_q <= INIT;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  assign pin_sync_out = sync_q;

endmodule

`default_nettype wire

// file: verilog/light_sensor_regs.v
// configuration, identification, event flag and result registers of the sensor,
// reached by a host over the two-wire serial port (scl input, sda open drain)
// assumes event inputs are one-cycle pulses and results are stable ref_clk logic
`timescale 1ns/1ps
`default_nettype none
`include "light_regs_consts.vh"

// How it works
// - ir select bit steers proximity diode into green converter, green diode off
// - gain bits 4:0 map codes 1,3,5,7,8,9,10 to gains; reset is 9
// - flag 7 sets on analog saturation of light and color results
// - flag 6 sets on ambient or reflective saturation in earlier proximity cycle
// - flag 5 sets when proximity passes thresholds for persistence count
// - flag 4 sets when clear light result passes thresholds for persistence
// - flag 3 sets when calibration finishes
// - flag 2 sets on zero result offset decrement with auto adjust on
// - flag 1 sets on front end saturation while emitter is on
// - flag 0 sets on front end saturation while emitter is off
// - writing one to a flag clears it, zero leaves it
// - with clear-on-read enabled, reading flags clears all eight afterwards
// - clear result low byte is readable, read only
// - clear result high byte is readable at next address
// - red result low byte is readable, read only
// - red result high byte is readable at next address
module light_sensor_regs #(
  parameter [6:0] BUS_ADDR = `BUS_ADDR_DEFAULT,
  parameter [2:0] REV_CODE = `REV_CODE_DEFAULT,
  parameter [5:0] TYPE_CODE = `TYPE_CODE_DEFAULT
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  input wire light_analog_sat_evt,
  input wire prox_sat_evt,
  input wire prox_threshold_evt,
  input wire light_threshold_evt,
  input wire calib_done_evt,
  input wire zero_offset_dec_evt,
  input wire prox_sat_emitter_on_evt,
  input wire prox_sat_emitter_off_evt,
  input wire offset_auto_adjust,
  input wire flags_read_clear,
  input wire [15:0] clear_result,
  input wire [15:0] red_result,
  output wire ir_to_green_select,
  output wire green_diode_connect,
  output wire emitter_current_double,
  output wire [4:0] light_gain_code,
  output wire [3:0] light_gain_log2,
  output wire light_gain_valid,
  output wire [7:0] event_flags
);

  ////////////////////////////////////////////////////////////////////////////
  // state codes of the serial port engine
  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_ADDR = 4'h1;
  localparam [3:0] ST_ACK_ADDR = 4'h2;
  localparam [3:0] ST_PTR = 4'h3;
  localparam [3:0] ST_ACK_BYTE = 4'h4;
  localparam [3:0] ST_WDATA = 4'h5;
  localparam [3:0] ST_RDATA = 4'h6;
  localparam [3:0] ST_HOST_ACK = 4'h7;

  ////////////////////////////////////////////////////////////////////////////
  // functions
  // gain as power of two; bit 4 marks a defined code
  function [4:0] gain_decode;
    input [4:0] code;
    begin
      case (code)
        `GAIN_CODE_1X: gain_decode = 5'h10;
        `GAIN_CODE_4X: gain_decode = 5'h12;
        `GAIN_CODE_16X: gain_decode = 5'h14;
        `GAIN_CODE_64X: gain_decode = 5'h16;
        `GAIN_CODE_128X: gain_decode = 5'h17;
        `GAIN_CODE_256X: gain_decode = 5'h18;
        `GAIN_CODE_512X: gain_decode = 5'h19;
        default: gain_decode = 5'h00;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation and bus conditions
  wire [1:0] pins_s;
  wire scl_s;
  wire sda_s;
  reg scl_p_q;
  reg sda_p_q;

  pin_sync #(
    .WIDTH(2),
    .INIT(2'h3)
  ) u_pin_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pin_in({scl_in, sda_in}),
    .pin_sync_out(pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_p_q;
  wire scl_fall = ~scl_s & scl_p_q;
  wire start_cond = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire stop_cond = scl_s & scl_p_q & ~sda_p_q & sda_s;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  reg [7:0] cfg_q;
  reg [7:0] flags_q;
  reg [7:0] flags_d;
  reg [3:0] state_q;
  reg [3:0] bit_cnt_q;
  reg [7:0] shift_q;
  reg [7:0] ptr_q;
  reg host_nack_q;
  reg sda_oe_q;
  reg sda_out_q;
  reg ir_sel_q;
  reg green_conn_q;
  reg current_double_q;
  reg [4:0] gain_code_q;
  reg [3:0] gain_log2_q;
  reg gain_valid_q;
  wire [4:0] gain_dec = gain_decode(cfg_q[`CFG_GAIN_MSB:`CFG_GAIN_LSB]);

  // read data for the byte at the pointer; unmapped bytes read zero
  reg [7:0] rd_byte;
  always @* begin
    case (ptr_q)
      `OFF_SENSOR_CONFIG_ONE: rd_byte = cfg_q;
      `OFF_REVISION_CODE: rd_byte = {5'h00, REV_CODE};
      `OFF_DEVICE_TYPE_CODE: rd_byte = {TYPE_CODE, 2'h0};
      `OFF_EVENT_FLAGS: rd_byte = flags_q;
      `OFF_CLEAR_RESULT_LOW: rd_byte = clear_result[7:0];
      `OFF_CLEAR_RESULT_HIGH: rd_byte = clear_result[15:8];
      `OFF_RED_RESULT_LOW: rd_byte = red_result[7:0];
      `OFF_RED_RESULT_HIGH: rd_byte = red_result[15:8];
      default: rd_byte = 8'h00;
    endcase
  end

  // a byte is loaded into the shifter either when the address ack ends on a read or
  // when the host acknowledges the previous read byte
  wire load_rd = scl_fall & (((state_q == ST_ACK_ADDR) & shift_q[0]) |
                             ((state_q == ST_HOST_ACK) & ~host_nack_q));
  wire wr_done = scl_fall & (state_q == ST_WDATA) & (bit_cnt_q == 4'h8);
  wire wr_flags = wr_done & (ptr_q == `OFF_EVENT_FLAGS);
  wire rd_flags = load_rd & (ptr_q == `OFF_EVENT_FLAGS) & flags_read_clear;

  ////////////////////////////////////////////////////////////////////////////
  // event flags: a set in the clearing cycle wins
  reg [7:0] flag_set;
  reg [7:0] flag_clr;
  always @* begin
    flag_set = 8'h00;
    flag_set[`FLAG_LIGHT_SAT] = light_analog_sat_evt;
    flag_set[`FLAG_PROX_SAT] = prox_sat_evt;
    flag_set[`FLAG_PROX_THR] = prox_threshold_evt;
    flag_set[`FLAG_LIGHT_THR] = light_threshold_evt;
    flag_set[`FLAG_CALIB_DONE] = calib_done_evt;
    flag_set[`FLAG_ZERO_DEC] = zero_offset_dec_evt & offset_auto_adjust;
    flag_set[`FLAG_SAT_EMIT_ON] = prox_sat_emitter_on_evt;
    flag_set[`FLAG_SAT_EMIT_OFF] = prox_sat_emitter_off_evt;
    flag_clr = 8'h00;
    if (wr_flags) begin
      flag_clr = shift_q;
    end
    if (rd_flags) begin
      flag_clr = 8'hFF;
    end
    flags_d = (flags_q & ~flag_clr) | flag_set;
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration register and its decoded outputs
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      cfg_q <= `CFG_RESET;
      flags_q <= `FLAGS_RESET;
      ir_sel_q <= 1'b0;
      green_conn_q <= 1'b1;
      current_double_q <= 1'b1;
      gain_code_q <= 5'h00;
      gain_log2_q <= 4'h0;
      gain_valid_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      // only the config byte stores writes; flags clear on written ones, identification and results ignore them
      if (wr_done & (ptr_q == `OFF_SENSOR_CONFIG_ONE)) begin
        cfg_q <= shift_q;
      end
      ir_sel_q <= cfg_q[`CFG_IR_SEL_BIT];
      green_conn_q <= ~cfg_q[`CFG_IR_SEL_BIT];
      current_double_q <= ~cfg_q[`CFG_CURRENT_NORM_BIT];
      gain_code_q <= cfg_q[`CFG_GAIN_MSB:`CFG_GAIN_LSB];
      gain_log2_q <= gain_dec[3:0];
      gain_valid_q <= gain_dec[4];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial port engine: sample on scl rise, change sda on scl fall
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      host_nack_q <= 1'b1;
      sda_oe_q <= 1'b0;
      sda_out_q <= 1'b0;
    end else if (start_cond) begin
      // repeated start keeps the pointer for a following read
      state_q <= ST_ADDR;
      bit_cnt_q <= 4'h0;
      sda_oe_q <= 1'b0;
    end else if (stop_cond) begin
      state_q <= ST_IDLE;
      sda_oe_q <= 1'b0;
    end else if (scl_rise) begin
      case (state_q)
        ST_ADDR, ST_PTR, ST_WDATA: begin
          shift_q <= {shift_q[6:0], sda_s};
          bit_cnt_q <= bit_cnt_q + 4'h1;
        end
        ST_HOST_ACK: begin
          host_nack_q <= sda_s;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (state_q)
        ST_ADDR: begin
          if (bit_cnt_q == 4'h8) begin
            if (shift_q[7:1] == BUS_ADDR) begin
              state_q <= ST_ACK_ADDR;
              sda_oe_q <= 1'b1;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_ACK_ADDR: begin
          bit_cnt_q <= 4'h0;
          if (shift_q[0]) begin
            state_q <= ST_RDATA;
            shift_q <= rd_byte;
            sda_oe_q <= ~rd_byte[7];
            bit_cnt_q <= 4'h1;
            ptr_q <= ptr_q + 8'h01;
          end else begin
            state_q <= ST_PTR;
            sda_oe_q <= 1'b0;
          end
        end
        ST_PTR: begin
          if (bit_cnt_q == 4'h8) begin
            ptr_q <= shift_q;
            state_q <= ST_ACK_BYTE;
            sda_oe_q <= 1'b1;
          end
        end
        ST_WDATA: begin
          if (bit_cnt_q == 4'h8) begin
            ptr_q <= ptr_q + 8'h01;
            state_q <= ST_ACK_BYTE;
            sda_oe_q <= 1'b1;
          end
        end
        ST_ACK_BYTE: begin
          state_q <= ST_WDATA;
          bit_cnt_q <= 4'h0;
          sda_oe_q <= 1'b0;
        end
        ST_RDATA: begin
          if (bit_cnt_q == 4'h8) begin
            state_q <= ST_HOST_ACK;
            sda_oe_q <= 1'b0;
          end else begin
            shift_q <= {shift_q[6:0], 1'b0};
            sda_oe_q <= ~shift_q[6];
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
        end
        ST_HOST_ACK: begin
          if (host_nack_q) begin
            // host ends the read; wait for stop or start
            state_q <= ST_IDLE;
          end else begin
            state_q <= ST_RDATA;
            shift_q <= rd_byte;
            sda_oe_q <= ~rd_byte[7];
            bit_cnt_q <= 4'h1;
            ptr_q <= ptr_q + 8'h01;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          sda_oe_q <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign sda_out = sda_out_q;
  assign sda_oe = sda_oe_q;
  assign ir_to_green_select = ir_sel_q;
  assign green_diode_connect = green_conn_q;
  assign emitter_current_double = current_double_q;
  assign light_gain_code = gain_code_q;
  assign light_gain_log2 = gain_log2_q;
  assign light_gain_valid = gain_valid_q;
  assign event_flags = flags_q;

endmodule

`default_nettype wire

// file: sim/light_sensor_regs_chk.sv
// concurrent checks on the ports of the sensor register slice
// assumes one ref_clk domain and a synchronous active-high sys_rst
`timescale 1ns/1ps
`default_nettype none
module light_sensor_regs_chk (
  input wire ref_clk,
  input wire sys_rst,
  input wire scl_in,
  input wire sda_oe,
  input wire light_analog_sat_evt,
  input wire prox_sat_evt,
  input wire prox_threshold_evt,
  input wire light_threshold_evt,
  input wire calib_done_evt,
  input wire zero_offset_dec_evt,
  input wire prox_sat_emitter_on_evt,
  input wire prox_sat_emitter_off_evt,
  input wire offset_auto_adjust,
  input wire ir_to_green_select,
  input wire green_diode_connect,
  input wire emitter_current_double,
  input wire [4:0] light_gain_code,
  input wire [3:0] light_gain_log2,
  input wire light_gain_valid,
  input wire [7:0] event_flags
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // zero flag only counts as a cause while auto adjust is on
  wire [7:0] evt = {light_analog_sat_evt, prox_sat_evt, prox_threshold_evt, light_threshold_evt,
    calib_done_evt, zero_offset_dec_evt & offset_auto_adjust, prox_sat_emitter_on_evt, prox_sat_emitter_off_evt};
  reg [2:0] up_q;
  // decoded outputs settle from reset values to cfg shortly after release
  always @(posedge ref_clk) up_q <= sys_rst ? 3'h0 : up_q + {2'h0, up_q != 3'h7};
  ////////////////////////////////////////////////////////////////////////////
  a_ir_green_pair: assert property (ir_to_green_select == !green_diode_connect)
    else $error("ir select and green connect disagree");
  a_gain_valid_set: assert property (light_gain_valid == (light_gain_code inside {5'h01, 5'h03, 5'h05,
    5'h07, 5'h08, 5'h09, 5'h0A})) else $error("gain valid wrong for code");
  a_gain_log2_map: assert property (light_gain_log2 == (light_gain_valid ? light_gain_code[3:0] - 4'h1 : 4'h0))
    else $error("gain log2 wrong for code");
  a_flag_set_evt: assert property (evt != 8'h00 |=> (event_flags & $past(evt)) == $past(evt))
    else $error("event did not set its flag");
  a_flag_no_cause: assert property (1'b1 |=> (event_flags & ~$past(event_flags) & ~$past(evt)) == 8'h00)
    else $error("flag set without event");
  a_zero_gate_off: assert property (zero_offset_dec_evt && !offset_auto_adjust && !event_flags[2] |=> !event_flags[2])
    else $error("zero flag set with auto adjust off");
  a_flag_clear_low: assert property ((~event_flags & $past(event_flags)) != 8'h00 |-> !scl_in)
    else $error("flag cleared outside a bus low phase");
  a_cfg_in_ack: assert property (up_q == 3'h7 && $changed({emitter_current_double, ir_to_green_select,
    light_gain_code}) |-> sda_oe) else $error("config outputs changed outside a write ack");
endmodule
bind light_sensor_regs light_sensor_regs_chk chk (.ref_clk, .sys_rst, .scl_in, .sda_oe, .light_analog_sat_evt,
  .prox_sat_evt, .prox_threshold_evt, .light_threshold_evt, .calib_done_evt, .zero_offset_dec_evt,
  .prox_sat_emitter_on_evt, .prox_sat_emitter_off_evt, .offset_auto_adjust, .ir_to_green_select,
  .green_diode_connect, .emitter_current_double, .light_gain_code, .light_gain_log2, .light_gain_valid,
  .event_flags);
`default_nettype wire

// file: sim/serial_host_model.sv
// two-wire bus master driving scl and pulling sda low, 64 ns bit period
// assumes sda_line is the resolved wire with pull-up; acts on ref_clk falls
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
  input wire ref_clk,
  input wire sda_line,
  output logic scl,
  output logic sda_low
);
  // scl stands high between frames, like a released line
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // also serves as repeated start, entered with scl low
  task automatic start_cond();
    sda_low = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(8);
    sda_low = 1'b1;
    tick(8);
    scl = 1'b0;
  endtask
  task automatic stop_cond();
    tick(4);
    sda_low = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(8);
    sda_low = 1'b0;
    tick(8);
  endtask
  // data changes mid low phase, sampled at the end of the high phase
  task automatic bit_io(input logic b, output logic r);
    tick(4);
    sda_low = ~b;
    tick(4);
    scl = 1'b1;
    tick(8);
    r = sda_line;
    scl = 1'b0;
  endtask
  task automatic byte_io(input logic [7:0] d, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
  endtask
endmodule
`default_nettype wire

// file: sim/test_light_sensor_regs.sv
// self-checking bench for the sensor register slice over its serial port
// assumes the host model and the bound checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
`include "light_regs_consts.vh"
module test_light_sensor_regs;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] evt = 8'h00;
  logic offset_auto_adjust = 1'b0;
  logic flags_read_clear = 1'b0;
  logic [15:0] clear_result = 16'hA55A;
  logic [15:0] red_result = 16'h3CC3;
  wire scl, host_low, sda_oe, sda_out, ir_sel, green_on, dbl, gvalid;
  wire [4:0] gcode;
  wire [3:0] glog2;
  wire [7:0] flags;
  wire sda_line = ~((sda_oe & ~sda_out) | host_low);
  int miscompares = 0;
  int num_checks = 0;
  // one color integration period in ref_clk cycles, a plain default
  localparam int INTEG_CYCLES = 256;
  logic [7:0] exp_bytes [$];
  logic [4:0] codes [8] = '{5'h01, 5'h03, 5'h05, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h02};
  logic [3:0] logs [8] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'h0};
  always #2 ref_clk = ~ref_clk;
  light_sensor_regs uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .light_analog_sat_evt(evt[7]), .prox_sat_evt(evt[6]),
    .prox_threshold_evt(evt[5]), .light_threshold_evt(evt[4]), .calib_done_evt(evt[3]),
    .zero_offset_dec_evt(evt[2]), .prox_sat_emitter_on_evt(evt[1]), .prox_sat_emitter_off_evt(evt[0]),
    .offset_auto_adjust(offset_auto_adjust), .flags_read_clear(flags_read_clear),
    .clear_result(clear_result), .red_result(red_result), .ir_to_green_select(ir_sel),
    .green_diode_connect(green_on), .emitter_current_double(dbl), .light_gain_code(gcode),
    .light_gain_log2(glog2), .light_gain_valid(gvalid), .event_flags(flags));
  serial_host_model host (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda_low(host_low));
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tx(input logic [7:0] d, input logic nak);
    logic [7:0] r;
    logic a;
    host.byte_io(d, r);
    host.bit_io(1'b1, a);
    chk({7'h00, a}, {7'h00, nak});
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    host.start_cond();
    tx({`BUS_ADDR_DEFAULT, 1'b0}, 1'b0);
    tx(ptr, 1'b0);
    tx(d, 1'b0);
    host.stop_cond();
  endtask
  // reads as many bytes as are queued, nack on the last
  task automatic rd(input logic [7:0] ptr);
    logic [7:0] r;
    logic a;
    host.start_cond();
    tx({`BUS_ADDR_DEFAULT, 1'b0}, 1'b0);
    tx(ptr, 1'b0);
    host.start_cond();
    tx({`BUS_ADDR_DEFAULT, 1'b1}, 1'b0);
    while (exp_bytes.size() > 0) begin
      host.byte_io(8'hFF, r);
      chk(r, exp_bytes.pop_front());
      host.bit_io(exp_bytes.size() == 0, a);
    end
    host.stop_cond();
  endtask
  task automatic pulse(input logic [7:0] v);
    evt = v;
    @(negedge ref_clk);
    evt = 8'h00;
    @(negedge ref_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge ref_clk);
    miscompares++;
    stop_test();
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (10) @(negedge ref_clk);
    chk({dbl, ir_sel, green_on, gcode}, 8'hA9);
    chk({3'h0, gvalid, glog2}, 8'h18);
    exp_bytes = '{`CFG_RESET, {5'h00, `REV_CODE_DEFAULT}, {`TYPE_CODE_DEFAULT, 2'b00}, 8'h00};
    rd(8'h90);
    $display("test reset values done");
    foreach (codes[i]) begin
      wr(8'h90, {3'b001, codes[i]});
      chk({dbl, ir_sel, green_on, gcode}, {3'b001, codes[i]});
      chk({3'h0, gvalid, glog2}, {3'h0, i < 7, logs[i]});
    end
    // reserved bit 7 stays at its default, ir steering on
    wr(8'h90, 8'h6A);
    chk({dbl, ir_sel, green_on, gcode}, 8'h4A);
    // steering is not tied to the color sequencer: let two integration periods pass
    repeat (2 * INTEG_CYCLES) @(negedge ref_clk);
    $display("test config done");
    pulse(8'hFF);
    chk(flags, 8'hFB);
    offset_auto_adjust = 1'b1;
    pulse(8'h04);
    chk(flags, 8'hFF);
    exp_bytes = '{8'hFF};
    rd(8'h93);
    chk(flags, 8'hFF);
    wr(8'h93, 8'h0F);
    chk(flags, 8'hF0);
    flags_read_clear = 1'b1;
    exp_bytes = '{8'hF0};
    rd(8'h93);
    chk(flags, 8'h00);
    flags_read_clear = 1'b0;
    $display("test flags done");
    wr(8'h94, 8'h00);
    wr(8'h91, 8'hFF);
    exp_bytes = '{8'h6A, {5'h00, `REV_CODE_DEFAULT}, {`TYPE_CODE_DEFAULT, 2'b00}, 8'h00, 8'h5A, 8'hA5,
      8'hC3, 8'h3C, 8'h00};
    rd(8'h90);
    host.start_cond();
    tx({`BUS_ADDR_DEFAULT ^ 7'h01, 1'b0}, 1'b1);
    host.stop_cond();
    $display("test results and address done");
    stop_test();
  end
endmodule
`default_nettype wire
